// *** shared/gp_pin_regs.vh ***
// Register indices, field positions, reset values and timing for the GPIO pin block.
// Assumes a 250 MHz clock and a register bus addressing 32-bit words.
`ifndef GP_PIN_REGS_VH
`define GP_PIN_REGS_VH

// Register indices; the byte address is four times the index
`define GP_IDX_SEL      10'h0F0
`define GP_IDX_CFG      10'h0F1
`define GP_IDX_ROUTE    10'h0F2
`define GP_IDX_DOUT     10'h0F3
`define GP_IDX_DIN      10'h0F4
`define GP_IDX_CFG3     10'h0F5
`define GP_IDX_STAT     10'h0F6
`define GP_IDX_MASK     10'h0F7

// Pin select fields
`define GP_SEL_MASK     8'h77
`define GP_PORT_MAX     3'h4

// Pin configuration fields
`define GP_CFG_OE       0
`define GP_CFG_PP       1
`define GP_CFG_PU       2
`define GP_CFG_LOCK     3
`define GP_CFG_ETYPE    4
`define GP_CFG_EPOL     5
`define GP_CFG_DEB      6
`define GP_CFG_RST_EVT  8'h44
`define GP_CFG_RST_NOEV 8'h04

// Event routing fields
`define GP_RT_IRQ       0
`define GP_RT_SMI       1
`define GP_RT_WAKE      2
`define GP_RT_RST       3'h1

// Chip configuration three fields
`define GP_C3_MUXLOCK   7
`define GP_C3_RST       8'h00

// Bus answers
`define GP_RESP_OKAY    2'h0
`define GP_RESP_SLVERR  2'h2

// Debounce period and clock
`define GP_DEB_NS       16000
`define GP_CLK_NS       4
`define GP_DEB_CYC      (`GP_DEB_NS / `GP_CLK_NS)

`endif

// *** rtl/gp_pin_pad.v ***
// One GPIO pin driver with input synchroniser.
// Assumes the pad resolves level from pinOut and pinOe; pull-up applied by the pad cell.
`timescale 1ns/100ps
module gp_pin_pad
(
  input  wire clock,
  input  wire rst_b,
  input  wire pinIn,
  input  wire outEnable,
  input  wire pushPull,
  input  wire outValue,
  input  wire pullEnable,
  output wire pinOut,
  output wire pinOe,
  output wire pullOn,
  output wire inSync
);

  reg syncAQ;
  reg syncBQ;

  // Input path is independent of the output enable
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Reset to the pulled-up idle level, so no false edge follows
      syncAQ <= 1'b1;
      syncBQ <= 1'b1;
    end
    else
    begin
      syncAQ <= pinIn;
      syncBQ <= syncAQ;
    end
  end

  assign inSync = syncBQ;
  // Open drain only ever pulls low; a one releases the line
  assign pinOe  = outEnable & (pushPull | ~outValue);
  assign pinOut = pushPull & outValue;
  // Pull-up follows its bit whether the pin is driven or read
  assign pullOn = pullEnable;

endmodule // gp_pin_pad

// *** rtl/gp_event_detect.v ***
// Debounce and edge or level detection for one event-capable pin.
// Assumes pinSync is already synchronised to clock.
`timescale 1ns/100ps
`include "gp_pin_regs.vh"
module gp_event_detect
(
  input  wire clock,
  input  wire rst_b,
  input  wire pinSync,
  input  wire debEnable,
  input  wire polarity,
  input  wire levelType,
  output wire eventHit
);

  localparam [31:0] DEB_CYC  = `GP_DEB_CYC;
  localparam [11:0] DEB_LAST = DEB_CYC[11:0] - 12'h001;

  reg  [11:0] stableQ;
  reg         rawPrevQ;
  reg         filtQ;
  reg         filtPrevQ;
  wire        filtNow;
  wire        active;
  wire        edgeSeen;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stableQ   <= 12'h000;
      rawPrevQ  <= 1'b1;
      filtQ     <= 1'b1;
      filtPrevQ <= 1'b1;
    end
    else
    begin
      rawPrevQ  <= pinSync;
      filtPrevQ <= filtNow;
      if (pinSync != rawPrevQ)
        stableQ <= 12'h000;
      else if (stableQ != DEB_LAST)
        stableQ <= stableQ + 12'h001;
      if (pinSync == rawPrevQ && stableQ == DEB_LAST)
        filtQ <= pinSync;
    end
  end

  // Without debounce the synchronised level passes straight through
  assign filtNow  = debEnable ? filtQ : pinSync;
  assign active   = polarity ? filtNow : ~filtNow;
  assign edgeSeen = polarity ? (filtNow & ~filtPrevQ) : (~filtNow & filtPrevQ);
  assign eventHit = levelType ? active : edgeSeen;

endmodule // gp_event_detect

// *** rtl/gp_pin_config.v ***
// GPIO bank of five 8-pin ports: indirect pin configuration, event routing, AXI4-Lite slave.
// Assumes an AXI4-Lite master with one write and one read in flight; pads outside.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "gp_pin_regs.vh"

// Contract
// - Lock bit sticks until reset
// - Lock freezes direction, type, pull-up, value
// - Mux selections fixed after mux lock set
// - Bit 2 enables pull-up, default on
// - Pull-up serves open-drain outputs and inputs
// - Bit 1 selects open-drain or push-pull
// - Bit 0 enables driver, input unaffected
// - Routing exists only for ports 0,1,4
// - Events routed to interrupt, management, wake
// - Routing bits: 2 wake, 1 mgmt, 0 irq
// - Select holds port 6-4, pin 2-0
// - Window reaches selected pin configuration
// - Bits 5,4 choose polarity and type
// - Bit 6 enables input debounce
module gp_pin_config
(
  input  wire        clock,
  input  wire        rst_b,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [39:0] gpioIn,
  output wire [39:0] gpioOut,
  output wire [39:0] gpioOe,
  output wire [39:0] gpioPullUp,
  output wire [4:0]  muxSelect,
  output wire        irqOut,
  output wire        systemMgmtInterrupt,
  output wire        powerWakeRequest
);

  // Per-pin settings, per-port views and the routed requests
  reg  [7:0]  cfgQ [0:39];
  reg  [2:0]  routeQ [0:39];
  reg  [7:0]  selQ;
  reg  [7:0]  chipCfgThreeQ;
  reg  [39:0] outQ;
  reg  [39:0] statusQ;
  reg  [39:0] maskQ;
  reg         irqQ;
  reg         smiQ;
  reg         wakeQ;

  // Bus channel state; each channel holds one item until the answer
  reg         awHeldQ;
  reg  [9:0]  awIdxQ;
  reg         wHeldQ;
  reg  [7:0]  wDataQ;
  reg         wLaneQ;
  reg         bvalidQ;
  reg  [1:0]  brespQ;
  reg         rvalidQ;
  reg  [31:0] rdataQ;
  reg  [1:0]  rrespQ;

  // Synchronised pins, detector hits and routing enables
  wire [39:0] pinSync;
  wire [39:0] pinEvent;
  wire [39:0] routeIrq;
  wire [39:0] routeSmi;
  wire [39:0] routeWake;
  wire [39:0] statusClr;
  // Slices of the selected port, one bit per pin
  wire [7:0]  selLock;
  wire [7:0]  selOut;
  wire [7:0]  selIn;
  wire [7:0]  selStatus;
  wire [7:0]  selMask;

  // Selected pin; ports 5 to 7 are reserved and reach nothing
  wire [2:0]  selPort  = selQ[6:4];
  wire [2:0]  selPin   = selQ[2:0];
  wire [5:0]  selIdx   = {selPort, selPin};
  wire        selValid = (selPort <= `GP_PORT_MAX);
  wire        selEvt   = (selPort == 3'h0) | (selPort == 3'h1) | (selPort == 3'h4);
  wire [7:0]  selCfg   = selValid ? cfgQ[selIdx] : 8'h00;
  wire [2:0]  selRoute = (selValid & selEvt) ? routeQ[selIdx] : 3'h0;

  // A write lands once address and data are both held
  wire        doWrite  = awHeldQ & wHeldQ & ~bvalidQ;
  wire        wrEnable = doWrite & wLaneQ;
  wire [9:0]  rIdx     = s_axi_araddr[11:2];
  wire        doRead   = s_axi_arvalid & ~rvalidQ;
  // Data in is read-only, so a write there is answered with an error
  wire        awMapped = (awIdxQ >= `GP_IDX_SEL) & (awIdxQ <= `GP_IDX_MASK) &
                         (awIdxQ != `GP_IDX_DIN);

  // Window write: lock only sets, locked fields hold, reserved fields stay zero
  wire [7:0]  cfgNext;
  assign cfgNext[7]   = 1'b0;
  assign cfgNext[6:4] = selEvt ? wDataQ[6:4] : 3'h0;
  assign cfgNext[3]   = selCfg[`GP_CFG_LOCK] | wDataQ[`GP_CFG_LOCK];
  assign cfgNext[2:0] = selCfg[`GP_CFG_LOCK] ? selCfg[2:0] : wDataQ[2:0];

  // Every pin has a pad; only ports 0, 1 and 4 carry detectors
  genvar g;
  generate
    for (g = 0; g < 40; g = g + 1)
    begin : pin
      gp_pin_pad u_pad
      (
        .clock      (clock),
        .rst_b      (rst_b),
        .pinIn      (gpioIn[g]),
        .outEnable  (cfgQ[g][`GP_CFG_OE]),
        .pushPull   (cfgQ[g][`GP_CFG_PP]),
        .outValue   (outQ[g]),
        .pullEnable (cfgQ[g][`GP_CFG_PU]),
        .pinOut     (gpioOut[g]),
        .pinOe      (gpioOe[g]),
        .pullOn     (gpioPullUp[g]),
        .inSync     (pinSync[g])
      );
      if ((g / 8) == 0 || (g / 8) == 1 || (g / 8) == 4)
      begin : evt
        gp_event_detect u_det
        (
          .clock     (clock),
          .rst_b     (rst_b),
          .pinSync   (pinSync[g]),
          .debEnable (cfgQ[g][`GP_CFG_DEB]),
          .polarity  (cfgQ[g][`GP_CFG_EPOL]),
          .levelType (cfgQ[g][`GP_CFG_ETYPE]),
          .eventHit  (pinEvent[g])
        );
        // Routing only exists where a detector does
        assign routeIrq[g]  = routeQ[g][`GP_RT_IRQ];
        assign routeSmi[g]  = routeQ[g][`GP_RT_SMI];
        assign routeWake[g] = routeQ[g][`GP_RT_WAKE];
      end
      else
      begin : noevt
        // Ports 2 and 3: no events and no routing
        assign pinEvent[g]  = 1'b0;
        assign routeIrq[g]  = 1'b0;
        assign routeSmi[g]  = 1'b0;
        assign routeWake[g] = 1'b0;
      end
      // A status read clears only the selected port's bits
      assign statusClr[g] = doRead & (rIdx == `GP_IDX_STAT) & (selPort == (g / 8));
    end
    for (g = 0; g < 8; g = g + 1)
    begin : sel
      // Pins of a reserved port read as zero
      localparam [31:0] PIN = g;
      wire [5:0] idx = {selPort, PIN[2:0]};
      assign selLock[g]   = selValid & cfgQ[idx][`GP_CFG_LOCK];
      assign selOut[g]    = selValid & outQ[idx];
      assign selIn[g]     = selValid & pinSync[idx];
      assign selStatus[g] = selValid & statusQ[idx];
      assign selMask[g]   = selValid & maskQ[idx];
    end
  endgenerate

  // Register file
  integer k;
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      selQ          <= 8'h00;
      chipCfgThreeQ <= `GP_C3_RST;
      outQ          <= 40'h00_0000_0000;
      maskQ         <= 40'h00_0000_0000;
      // Ports 2 and 3 reset without event bits
      for (k = 0; k < 40; k = k + 1)
      begin
        cfgQ[k]   <= (k >= 16 && k < 32) ? `GP_CFG_RST_NOEV : `GP_CFG_RST_EVT;
        routeQ[k] <= `GP_RT_RST;
      end
    end
    else if (wrEnable)
    begin
      case (awIdxQ)
        // Reserved select bits are dropped on the way in
        `GP_IDX_SEL:
          selQ <= wDataQ & `GP_SEL_MASK;
        `GP_IDX_CFG:
          if (selValid)
            cfgQ[selIdx] <= cfgNext;
        // Ports without detection keep routing off
        `GP_IDX_ROUTE:
          if (selValid && selEvt)
            routeQ[selIdx] <= wDataQ[2:0];
        // Locked pins keep their output value
        `GP_IDX_DOUT:
          if (selValid)
            for (k = 0; k < 8; k = k + 1)
              if (!selLock[k])
                outQ[{selPort, k[2:0]}] <= wDataQ[k];
        // Mux lock sets once and freezes the selections behind it
        `GP_IDX_CFG3:
        begin
          chipCfgThreeQ[`GP_C3_MUXLOCK] <= chipCfgThreeQ[`GP_C3_MUXLOCK]
                                           | wDataQ[`GP_C3_MUXLOCK];
          if (!chipCfgThreeQ[`GP_C3_MUXLOCK])
            chipCfgThreeQ[4:0] <= wDataQ[4:0];
        end
        // The mask gates only the interrupt request
        `GP_IDX_MASK:
          if (selValid)
            for (k = 0; k < 8; k = k + 1)
              maskQ[{selPort, k[2:0]}] <= wDataQ[k];
        default:
          selQ <= selQ;
      endcase
    end
  end

  // Sticky event status; a new event outweighs a clearing read
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      statusQ <= 40'h00_0000_0000;
      irqQ    <= 1'b0;
      smiQ    <= 1'b0;
      wakeQ   <= 1'b0;
    end
    else
    begin
      statusQ <= pinEvent | (statusQ & ~statusClr);
      // Requests come from flops, so they never glitch
      irqQ    <= |(statusQ & maskQ & routeIrq);
      smiQ    <= |(statusQ & routeSmi);
      wakeQ   <= |(statusQ & routeWake);
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeldQ <= 1'b0;
      awIdxQ  <= 10'h000;
      wHeldQ  <= 1'b0;
      wDataQ  <= 8'h00;
      wLaneQ  <= 1'b0;
      bvalidQ <= 1'b0;
      brespQ  <= `GP_RESP_OKAY;
    end
    else
    begin
      // A held channel refuses a second item until the answer is taken
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeldQ <= 1'b1;
        awIdxQ  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata[7:0];
        wLaneQ <= s_axi_wstrb[0];
      end
      // Answer and release both channels at one edge
      if (doWrite)
      begin
        awHeldQ <= 1'b0;
        wHeldQ  <= 1'b0;
        bvalidQ <= 1'b1;
        brespQ  <= awMapped ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
      end
      else if (bvalidQ && s_axi_bready)
        bvalidQ <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalidQ <= 1'b0;
      rdataQ  <= 32'h0000_0000;
      rrespQ  <= `GP_RESP_OKAY;
    end
    else if (doRead)
    begin
      rvalidQ <= 1'b1;
      rrespQ  <= `GP_RESP_OKAY;
      // Unmapped indices answer with an error and zero data
      case (rIdx)
        `GP_IDX_SEL:   rdataQ <= {24'h00_0000, selQ};
        `GP_IDX_CFG:   rdataQ <= {24'h00_0000, selCfg};
        `GP_IDX_ROUTE: rdataQ <= {29'h0000_0000, selRoute};
        `GP_IDX_DOUT:  rdataQ <= {24'h00_0000, selOut};
        `GP_IDX_DIN:   rdataQ <= {24'h00_0000, selIn};
        `GP_IDX_CFG3:  rdataQ <= {24'h00_0000, chipCfgThreeQ};
        `GP_IDX_STAT:  rdataQ <= {24'h00_0000, selStatus};
        `GP_IDX_MASK:  rdataQ <= {24'h00_0000, selMask};
        default:
        begin
          rdataQ <= 32'h0000_0000;
          rrespQ <= `GP_RESP_SLVERR;
        end
      endcase
    end
    // The answer stands until the master takes it
    else if (rvalidQ && s_axi_rready)
      rvalidQ <= 1'b0;
  end

  // Write channel
  assign s_axi_awready       = ~awHeldQ & ~bvalidQ;
  assign s_axi_wready        = ~wHeldQ & ~bvalidQ;
  assign s_axi_bvalid        = bvalidQ;
  assign s_axi_bresp         = brespQ;

  // Read channel: arready falls while an answer stands
  assign s_axi_arready       = ~rvalidQ;
  assign s_axi_rvalid        = rvalidQ;
  assign s_axi_rdata         = rdataQ;
  assign s_axi_rresp         = rrespQ;

  // Pins and routed requests
  assign muxSelect           = chipCfgThreeQ[4:0];
  assign irqOut              = irqQ;
  assign systemMgmtInterrupt = smiQ;
  assign powerWakeRequest    = wakeQ;

endmodule // gp_pin_config

// *** bench/gp_pin_config_assertions.sv ***
// Checker of bus answers and pad outputs of gp_pin_config.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/100ps
module gp_pin_config_assertions
(
  input wire        clock,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [39:0] gpioOe,
  input wire [39:0] gpioPullUp,
  input wire [4:0]  muxSelect
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_pull_reset: assert property (
    $rose(rst_b) |-> &gpioPullUp)
    else $error("pull-up off after reset");
  // Pad and mux settings move only at the edge where a write takes effect
  a_mux_by_write: assert property (
    !$stable(muxSelect) |-> $rose(s_axi_bvalid))
    else $error("mux moved without write");
  a_drive_by_write: assert property (
    !$stable(gpioOe) |-> s_axi_bvalid && !$past(s_axi_bvalid))
    else $error("drive moved without write");
endmodule // gp_pin_config_assertions

bind gp_pin_config gp_pin_config_assertions chk_u
(
  .clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .gpioOe, .gpioPullUp, .muxSelect
);

// *** bench/gp_pin_config_tb.sv ***
// Bench of gp_pin_config: registers, lock, pad drive, event routing.
// Assumes the checker binds itself; the bench is bus master and pads.
`timescale 1ns/100ps
`include "gp_pin_regs.vh"
module gp_pin_config_tb;
  logic        clock;
  logic        rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [39:0] gpioIn = 40'hFF_FFFF_FFFF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         irqOut, systemMgmtInterrupt, powerWakeRequest;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [39:0]  gpioOut, gpioOe, gpioPullUp;
  wire [4:0]   muxSelect;
  int          fails = 0;
  int          comparisons = 0;

  gp_pin_config dut_u
  (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpioIn, .gpioOut, .gpioOe,
    .gpioPullUp, .muxSelect, .irqOut, .systemMgmtInterrupt, .powerWakeRequest
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Ready is raised only after the answer shows, so a held answer is exercised
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [1:0] er = `GP_RESP_OKAY);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (a || w)
    begin
      @(posedge clock);
      a = a && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= a;
      s_axi_wvalid <= w;
    end
    while (!(s_axi_bvalid && s_axi_bready))
    begin
      s_axi_bready <= s_axi_bvalid;
      @(posedge clock);
    end
    s_axi_bready <= 1'b0;
    chk($sformatf("bresp %h", idx), s_axi_bresp, er);
    @(posedge clock);
  endtask

  task automatic rc(input logic [9:0] idx, input logic [7:0] e,
                    input logic [1:0] er = `GP_RESP_OKAY);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
      @(posedge clock);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!(s_axi_rvalid && s_axi_rready))
    begin
      s_axi_rready <= s_axi_rvalid;
      @(posedge clock);
    end
    s_axi_rready <= 1'b0;
    chk($sformatf("reg %h", idx), {s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
    @(posedge clock);
  endtask

  // Tests take about 4400 cycles, most of it the debounce wait
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    tally_and_finish;
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rc(`GP_IDX_SEL, 8'h00);
    rc(`GP_IDX_CFG, 8'h44);
    rc(`GP_IDX_ROUTE, 8'h01);
    chk("pullup", gpioPullUp, 40'hFF_FFFF_FFFF);
    wr(`GP_IDX_SEL, 8'h20);
    rc(`GP_IDX_CFG, 8'h04);
    wr(`GP_IDX_ROUTE, 8'h07);
    rc(`GP_IDX_ROUTE, 8'h00);
    wr(`GP_IDX_SEL, 8'hFF);
    rc(`GP_IDX_SEL, 8'h77);
    wr(`GP_IDX_SEL, 8'h50);
    rc(`GP_IDX_CFG, 8'h00);
    $display("test reset values done");
    wr(`GP_IDX_SEL, 8'h00);
    wr(`GP_IDX_CFG, 8'hFF);
    rc(`GP_IDX_CFG, 8'h7F);
    wr(`GP_IDX_CFG, 8'h00);
    rc(`GP_IDX_CFG, 8'h0F);
    wr(`GP_IDX_SEL, 8'h01);
    wr(`GP_IDX_CFG, 8'h01);
    chk("od low", {gpioOe[1], gpioOut[1], gpioPullUp[1]}, 3'b100);
    wr(`GP_IDX_DOUT, 8'hFF);
    rc(`GP_IDX_DOUT, 8'hFE);
    chk("od release", {gpioOe[1:0], gpioOut[1:0]}, 4'b0100);
    wr(`GP_IDX_CFG, 8'h03);
    chk("push pull", {gpioOe[1], gpioOut[1]}, 2'b11);
    wr(`GP_IDX_CFG, 8'h06);
    chk("drive off", {gpioOe[1], gpioPullUp[1]}, 2'b01);
    $display("test lock and drive done");
    gpioIn[31:24] <= 8'hA5;
    wr(`GP_IDX_SEL, 8'h30);
    rc(`GP_IDX_DIN, 8'hA5);
    wr(`GP_IDX_DIN, 8'h00, `GP_RESP_SLVERR);
    rc(10'h000, 8'h00, `GP_RESP_SLVERR);
    wr(`GP_IDX_CFG3, 8'h85);
    chk("mux", muxSelect, 5'h05);
    wr(`GP_IDX_CFG3, 8'h03);
    rc(`GP_IDX_CFG3, 8'h85);
    chk("mux locked", muxSelect, 5'h05);
    $display("test input and mux done");
    wr(`GP_IDX_SEL, 8'h10);
    wr(`GP_IDX_CFG, 8'h00);
    wr(`GP_IDX_ROUTE, 8'hFF);
    rc(`GP_IDX_ROUTE, 8'h07);
    wr(`GP_IDX_MASK, 8'h01);
    gpioIn[8] <= 1'b0;
    repeat (10) @(posedge clock);
    chk("routed", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b111);
    rc(`GP_IDX_STAT, 8'h01);
    repeat (4) @(posedge clock);
    chk("cleared", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b000);
    wr(`GP_IDX_MASK, 8'h00);
    wr(`GP_IDX_ROUTE, 8'h03);
    gpioIn[8] <= 1'b1;
    repeat (10) @(posedge clock);
    chk("rise ignored", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b000);
    gpioIn[8] <= 1'b0;
    repeat (10) @(posedge clock);
    chk("mgmt only", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b010);
    $display("test event routing done");
    wr(`GP_IDX_CFG, 8'h40);
    rc(`GP_IDX_STAT, 8'h01);
    repeat (100) @(posedge clock);
    chk("debounce wait", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b000);
    repeat (4000) @(posedge clock);
    chk("debounced", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b010);
    rc(`GP_IDX_STAT, 8'h01);
    wr(`GP_IDX_CFG, 8'h30);
    gpioIn[8] <= 1'b1;
    repeat (10) @(posedge clock);
    rc(`GP_IDX_STAT, 8'h01);
    repeat (4) @(posedge clock);
    chk("level held", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b010);
    gpioIn[8] <= 1'b0;
    repeat (10) @(posedge clock);
    rc(`GP_IDX_STAT, 8'h01);
    repeat (4) @(posedge clock);
    chk("level gone", {irqOut, systemMgmtInterrupt, powerWakeRequest}, 3'b000);
    $display("test debounce and level done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rc(`GP_IDX_CFG, 8'h44);
    rc(`GP_IDX_CFG3, 8'h00);
    chk("mux reset", muxSelect, 5'h00);
    s_axi_wstrb <= 4'h0;
    wr(`GP_IDX_SEL, 8'h33);
    s_axi_wstrb <= 4'hF;
    rc(`GP_IDX_SEL, 8'h00);
    $display("test mid-run reset done");
    tally_and_finish;
  end
endmodule // gp_pin_config_tb
